// [src/pdc_regs.sv]
// Loop divider control register bank with a Wishbone slave port.
// Function
// - M divider bypasses at code zero, else divides by code plus one.
// - Post divider is two at codes 0 and 1, else code plus one; reset 7.
// - A sync event resyncs first loop channels while allowed; reset one.
// - Power-down high stops the loop, and its rise resets calibration.
// - The primary reference doubler runs while its bit is one; reset one.
// - Pump code steps 0.4 mA for one to seven, 6.4 mA at eight; reset 8.
`timescale 1ns/1ns
module pdc_regs (
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  input  wire logic                               wb_cyc_i,
  input  wire logic                               wb_stb_i,
  input  wire logic                               wb_we_i,
  input  wire logic [pdc_pkg::ADR_W-1:0]          wb_adr_i,
  input  wire logic [pdc_pkg::SEL_W-1:0]          wb_sel_i,
  input  wire logic [pdc_pkg::DAT_W-1:0]          wb_dat_i,
  output logic      [pdc_pkg::DAT_W-1:0]          wb_dat_o,
  output logic                                    wb_ack_o,
  input  wire logic                               sync_pin_i,
  input  wire logic [pdc_pkg::CHANNELS-1:0]       chan_on_first_loop_i,
  output logic      [pdc_pkg::M_W-1:0]            second_loop_m_divider_o,
  output logic                                    second_loop_m_bypass_o,
  output logic      [pdc_pkg::M_RATIO_W-1:0]      second_loop_m_ratio_o,
  output logic      [pdc_pkg::P_W-1:0]            first_loop_post_divider_o,
  output logic      [pdc_pkg::P_RATIO_W-1:0]      first_loop_post_ratio_o,
  output logic                                    first_loop_resync_allow_o,
  output logic      [pdc_pkg::CHANNELS-1:0]       first_loop_chan_resync_o,
  output logic                                    first_loop_power_down_o,
  output logic                                    first_loop_enable_o,
  output logic                                    first_loop_calib_reset_o,
  output logic                                    primary_ref_doubler_on_o,
  output logic      [pdc_pkg::CP_W-1:0]           first_loop_pump_current_o,
  output logic      [pdc_pkg::CUR_W-1:0]          first_loop_pump_tenth_ma_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pdc_pkg::pdc_bus_e                 bus_state;
  pdc_pkg::pdc_bus_e                 next_bus_state;
  pdc_pkg::pdc_regs_s                regs;
  pdc_pkg::pdc_regs_s                next_regs;
  logic [pdc_pkg::DAT_W-1:0]         next_dat;
  logic                              next_ack;
  logic                              req;
  logic                              wr_en;
  logic [pdc_pkg::DAT_W-1:0]         rd_word;
  logic                              sync_level;
  logic                              sync_prev;
  logic                              next_sync_prev;
  logic                              sync_event;
  logic [pdc_pkg::M_RATIO_W-1:0]     next_m_ratio;
  logic                              next_m_bypass;
  logic [pdc_pkg::P_RATIO_W-1:0]     next_p_ratio;
  logic [pdc_pkg::CHANNELS-1:0]      next_chan_resync;
  logic                              next_calib_reset;
  logic [pdc_pkg::CUR_W-1:0]         next_pump_tenth_ma;

  // ----------------------------------------------------------------------
  // Sync pin input
  // ----------------------------------------------------------------------
  pdc_sync2 #(
    .W (1)
  ) u_sync_pin (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (sync_pin_i),
    .sync_o  (sync_level)
  );

  always_comb begin
    next_sync_prev = sync_level;
    sync_event = sync_level & ~sync_prev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= next_sync_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    next_bus_state = bus_state;
    next_ack = 1'b0;
    wr_en = 1'b0;
    unique case (bus_state)
      pdc_pkg::BUS_IDLE: begin
        if (req) begin
          next_bus_state = pdc_pkg::BUS_ACK;
          next_ack = 1'b1;
        end
      end
      pdc_pkg::BUS_ACK: begin
        next_bus_state = pdc_pkg::BUS_IDLE;
        wr_en = req & wb_we_i & wb_sel_i[0];
      end
      default: begin
        next_bus_state = pdc_pkg::BUS_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    unique case (wb_adr_i)
      pdc_pkg::ADDR_M_DIVIDE: begin
        rd_word[pdc_pkg::M_LSB +: pdc_pkg::M_W] = regs.m_code;
      end
      pdc_pkg::ADDR_CTRL_ZERO: begin
        rd_word[pdc_pkg::P_LSB +: pdc_pkg::P_W] = regs.p_code;
        rd_word[pdc_pkg::SYNC_BIT] = regs.sync_allow;
        rd_word[pdc_pkg::PDN_BIT] = regs.pdn;
      end
      pdc_pkg::ADDR_CTRL_ONE: begin
        rd_word[pdc_pkg::DBL_BIT] = regs.dbl;
        rd_word[pdc_pkg::CP_LSB +: pdc_pkg::CP_W] = regs.cp_code;
      end
      default: begin
        rd_word = '0;
      end
    endcase
    next_dat = (next_ack && !wb_we_i) ? rd_word : '0;
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_comb begin
    next_regs = regs;
    if (wr_en) begin
      unique case (wb_adr_i)
        pdc_pkg::ADDR_M_DIVIDE: begin
          next_regs.m_code = wb_dat_i[pdc_pkg::M_LSB +: pdc_pkg::M_W];
        end
        pdc_pkg::ADDR_CTRL_ZERO: begin
          next_regs.p_code = wb_dat_i[pdc_pkg::P_LSB +: pdc_pkg::P_W];
          next_regs.sync_allow = wb_dat_i[pdc_pkg::SYNC_BIT];
          next_regs.pdn = wb_dat_i[pdc_pkg::PDN_BIT];
        end
        pdc_pkg::ADDR_CTRL_ONE: begin
          next_regs.dbl = wb_dat_i[pdc_pkg::DBL_BIT];
          next_regs.cp_code = wb_dat_i[pdc_pkg::CP_LSB +: pdc_pkg::CP_W];
        end
        default: begin
          next_regs = regs;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  always_comb begin
    next_m_bypass = (next_regs.m_code == pdc_pkg::M_BYPASS_CODE);
    if (next_m_bypass) begin
      next_m_ratio = pdc_pkg::M_BYPASS_RATIO;
    end else begin
      next_m_ratio = {1'b0, next_regs.m_code} + pdc_pkg::M_BYPASS_RATIO;
    end
    if (next_regs.p_code <= pdc_pkg::P_LOW_CODE) begin
      next_p_ratio = pdc_pkg::P_LOW_RATIO;
    end else begin
      next_p_ratio = {1'b0, next_regs.p_code} + 4'h1;
    end
    if (next_regs.cp_code == pdc_pkg::CP_TOP_CODE) begin
      next_pump_tenth_ma = pdc_pkg::CP_TOP_CUR;
    end else if (next_regs.cp_code <= pdc_pkg::CP_STEP_MAX) begin
      next_pump_tenth_ma = 7'(pdc_pkg::CP_STEP_CUR * next_regs.cp_code);
    end else begin
      next_pump_tenth_ma = pdc_pkg::CP_NONE_CUR;
    end
    if (sync_event && regs.sync_allow) begin
      next_chan_resync = chan_on_first_loop_i;
    end else begin
      next_chan_resync = '0;
    end
    next_calib_reset = next_regs.pdn & ~regs.pdn;
  end

  // ----------------------------------------------------------------------
  // Bus and register state
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= pdc_pkg::BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      bus_state <= next_bus_state;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs <= pdc_pkg::REGS_RST;
    end else begin
      regs <= next_regs;
    end
  end

  // ----------------------------------------------------------------------
  // Second loop M divider outputs
  // ----------------------------------------------------------------------
  // M divider outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_loop_m_divider_o <= pdc_pkg::M_RST;
      second_loop_m_bypass_o <= 1'b1;
      second_loop_m_ratio_o <= pdc_pkg::M_BYPASS_RATIO;
    end else begin
      second_loop_m_divider_o <= next_regs.m_code;
      second_loop_m_bypass_o <= next_m_bypass;
      second_loop_m_ratio_o <= next_m_ratio;
    end
  end

  // ----------------------------------------------------------------------
  // First loop post divider outputs
  // ----------------------------------------------------------------------
  // post divider outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_loop_post_divider_o <= pdc_pkg::P_RST;
      first_loop_post_ratio_o <= 4'h8;
    end else begin
      first_loop_post_divider_o <= next_regs.p_code;
      first_loop_post_ratio_o <= next_p_ratio;
    end
  end

  // ----------------------------------------------------------------------
  // First loop resync outputs
  // ----------------------------------------------------------------------
  // resync outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_loop_resync_allow_o <= pdc_pkg::SYNC_RST;
      first_loop_chan_resync_o <= '0;
    end else begin
      first_loop_resync_allow_o <= next_regs.sync_allow;
      first_loop_chan_resync_o <= next_chan_resync;
    end
  end

  // ----------------------------------------------------------------------
  // First loop power control outputs
  // ----------------------------------------------------------------------
  // loop enable control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_loop_power_down_o <= pdc_pkg::PDN_RST;
      first_loop_enable_o <= ~pdc_pkg::PDN_RST;
      first_loop_calib_reset_o <= 1'b0;
    end else begin
      first_loop_power_down_o <= next_regs.pdn;
      first_loop_enable_o <= ~next_regs.pdn;
      first_loop_calib_reset_o <= next_calib_reset;
    end
  end

  // ----------------------------------------------------------------------
  // Primary reference doubler output
  // ----------------------------------------------------------------------
  // doubler enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_ref_doubler_on_o <= pdc_pkg::DBL_RST;
    end else begin
      primary_ref_doubler_on_o <= next_regs.dbl;
    end
  end

  // ----------------------------------------------------------------------
  // Charge pump current outputs
  // ----------------------------------------------------------------------
  // pump current outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_loop_pump_current_o <= pdc_pkg::CP_RST;
      first_loop_pump_tenth_ma_o <= pdc_pkg::CP_TOP_CUR;
    end else begin
      first_loop_pump_current_o <= next_regs.cp_code;
      first_loop_pump_tenth_ma_o <= next_pump_tenth_ma;
    end
  end

endmodule

// [src/pdc_pkg.sv]
// Package of constants and types for the loop divider control registers.
package pdc_pkg;

  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADR_W = 10;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned CHANNELS = 8;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_M_DIVIDE = 8'h37;
  localparam logic [7:0] IDX_CTRL_ZERO = 8'h38;
  localparam logic [7:0] IDX_CTRL_ONE = 8'h39;
  localparam logic [ADR_W-1:0] ADDR_M_DIVIDE = {IDX_M_DIVIDE, 2'b00};
  localparam logic [ADR_W-1:0] ADDR_CTRL_ZERO = {IDX_CTRL_ZERO, 2'b00};
  localparam logic [ADR_W-1:0] ADDR_CTRL_ONE = {IDX_CTRL_ONE, 2'b00};

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned M_LSB = 0;
  localparam int unsigned M_W = 5;
  localparam int unsigned P_LSB = 2;
  localparam int unsigned P_W = 3;
  localparam int unsigned SYNC_BIT = 1;
  localparam int unsigned PDN_BIT = 0;
  localparam int unsigned DBL_BIT = 4;
  localparam int unsigned CP_LSB = 0;
  localparam int unsigned CP_W = 4;
  localparam int unsigned M_RATIO_W = 6;
  localparam int unsigned P_RATIO_W = 4;
  localparam int unsigned CUR_W = 7;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [M_W-1:0] M_RST = 5'h00;
  localparam logic [P_W-1:0] P_RST = 3'h7;
  localparam logic SYNC_RST = 1'b1;
  localparam logic PDN_RST = 1'b0;
  localparam logic DBL_RST = 1'b1;
  localparam logic [CP_W-1:0] CP_RST = 4'h8;

  // ----------------------------------------------------------------------
  // Decode constants
  // ----------------------------------------------------------------------
  localparam logic [M_W-1:0] M_BYPASS_CODE = 5'h00;
  localparam logic [M_RATIO_W-1:0] M_BYPASS_RATIO = 6'h01;
  localparam logic [P_W-1:0] P_LOW_CODE = 3'h1;
  localparam logic [P_RATIO_W-1:0] P_LOW_RATIO = 4'h2;
  localparam logic [CP_W-1:0] CP_STEP_MAX = 4'h7;
  localparam logic [CP_W-1:0] CP_TOP_CODE = 4'h8;
  localparam logic [CUR_W-1:0] CP_STEP_CUR = 7'h04;
  localparam logic [CUR_W-1:0] CP_TOP_CUR = 7'h40;
  localparam logic [CUR_W-1:0] CP_NONE_CUR = 7'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [M_W-1:0]  m_code;
    logic [P_W-1:0]  p_code;
    logic            sync_allow;
    logic            pdn;
    logic            dbl;
    logic [CP_W-1:0] cp_code;
  } pdc_regs_s;

  localparam pdc_regs_s REGS_RST = '{
    m_code: M_RST, p_code: P_RST, sync_allow: SYNC_RST,
    pdn: PDN_RST, dbl: DBL_RST, cp_code: CP_RST};

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } pdc_bus_e;

endpackage

// [src/pdc_sync2.sv]
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
module pdc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage_one;
  logic [W-1:0] next_stage_one;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage_one = async_i;
    next_sync = stage_one;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_one <= '0;
      sync_o <= '0;
    end else begin
      stage_one <= next_stage_one;
      sync_o <= next_sync;
    end
  end

endmodule

// [sim/pdc_regs_asserts.sv]
// Checker for bus timing and field decoding of the divider register bank.
`timescale 1ns/1ns
module pdc_regs_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sync_pin_i,
  input wire logic [7:0]  chan_on_first_loop_i,
  input wire logic [4:0]  second_loop_m_divider_o,
  input wire logic        second_loop_m_bypass_o,
  input wire logic [5:0]  second_loop_m_ratio_o,
  input wire logic [2:0]  first_loop_post_divider_o,
  input wire logic [3:0]  first_loop_post_ratio_o,
  input wire logic        first_loop_resync_allow_o,
  input wire logic [7:0]  first_loop_chan_resync_o,
  input wire logic        first_loop_power_down_o,
  input wire logic        first_loop_enable_o,
  input wire logic        first_loop_calib_reset_o,
  input wire logic [3:0]  first_loop_pump_current_o,
  input wire logic [6:0]  first_loop_pump_tenth_ma_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------
  // Assertions
  // ----------
  m_decode_a: assert property (
    second_loop_m_ratio_o == (second_loop_m_bypass_o ? 6'h01
      : {1'b0, second_loop_m_divider_o} + 6'h01) &&
    second_loop_m_bypass_o == (second_loop_m_divider_o == 5'h00))
    else $error("m divider decode wrong");
  post_decode_a: assert property (
    first_loop_post_ratio_o == ((first_loop_post_divider_o < 3'h2) ? 4'h2
      : {1'b0, first_loop_post_divider_o} + 4'h1))
    else $error("post divider decode wrong");
  pump_decode_a: assert property (
    first_loop_pump_tenth_ma_o == ((first_loop_pump_current_o == 4'h8) ? 7'h40
      : (first_loop_pump_current_o inside {[4'h1:4'h7]})
      ? {1'b0, first_loop_pump_current_o, 2'b00} : 7'h00))
    else $error("pump current decode wrong");
  enable_inv_a: assert property (
    first_loop_enable_o == !first_loop_power_down_o)
    else $error("enable not inverse of power down");
  calib_edge_a: assert property (
    first_loop_calib_reset_o == $rose(first_loop_power_down_o))
    else $error("calibration reset pulse wrong");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  rdata_idle_a: assert property (
    wb_dat_o[31:8] == 24'h00_0000 && (wb_ack_o || wb_dat_o == 32'h0000_0000))
    else $error("read data not zero outside ack");
  resync_mask_a: assert property (
    first_loop_chan_resync_o != 8'h00 |-> first_loop_resync_allow_o &&
    first_loop_chan_resync_o == chan_on_first_loop_i)
    else $error("resync mask wrong");
  resync_time_a: assert property (
    $rose(sync_pin_i) && first_loop_resync_allow_o &&
    chan_on_first_loop_i != 8'h00 |->
    ##[2:6] first_loop_chan_resync_o != 8'h00)
    else $error("resync pulse missing");
  cover property (first_loop_calib_reset_o);
  cover property (first_loop_chan_resync_o != 8'h00);
  cover property (wb_ack_o);
endmodule

bind pdc_regs pdc_regs_asserts pdc_regs_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_pin_i(sync_pin_i),
  .chan_on_first_loop_i(chan_on_first_loop_i),
  .second_loop_m_divider_o(second_loop_m_divider_o),
  .second_loop_m_bypass_o(second_loop_m_bypass_o),
  .second_loop_m_ratio_o(second_loop_m_ratio_o),
  .first_loop_post_divider_o(first_loop_post_divider_o),
  .first_loop_post_ratio_o(first_loop_post_ratio_o),
  .first_loop_resync_allow_o(first_loop_resync_allow_o),
  .first_loop_chan_resync_o(first_loop_chan_resync_o),
  .first_loop_power_down_o(first_loop_power_down_o),
  .first_loop_enable_o(first_loop_enable_o),
  .first_loop_calib_reset_o(first_loop_calib_reset_o),
  .first_loop_pump_current_o(first_loop_pump_current_o),
  .first_loop_pump_tenth_ma_o(first_loop_pump_tenth_ma_o));

// [sim/pdc_regs_test.sv]
// Self-checking bench for the loop divider control register bank.
`timescale 1ns/1ns
module pdc_regs_test;
  typedef struct packed {
    logic [9:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [6:0] dec;
  } pdc_row_s;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic        sync_pin = 1'b0;
  logic [7:0]  chans = 8'h00;
  logic [31:0] rd, dat_o;
  logic        ack, m_bypass, allow, pdn, en, calib, dbl;
  logic [5:0]  m_ratio;
  logic [3:0]  post_ratio;
  logic [7:0]  resync;
  logic [6:0]  tenth;
  logic [4:0]  m_code;
  logic [2:0]  p_code;
  logic [3:0]  cp_code;
  int          errors = 0;
  int          check_count = 0;
  int          calib_n = 0;
  int          sync_n = 0;
  logic [7:0]  sync_mask = 8'h00;
  pdc_row_s    rows [14] = '{
    '{10'h0DC, 8'h00, 8'h00, 7'h01}, '{10'h0DC, 8'h01, 8'h01, 7'h02},
    '{10'h0DC, 8'h1E, 8'h1E, 7'h1F}, '{10'h0DC, 8'hFF, 8'h1F, 7'h20},
    '{10'h0E0, 8'h02, 8'h02, 7'h02}, '{10'h0E0, 8'h04, 8'h04, 7'h02},
    '{10'h0E0, 8'h0A, 8'h0A, 7'h03}, '{10'h0E0, 8'hFE, 8'h1E, 7'h08},
    '{10'h0E4, 8'h11, 8'h11, 7'h04}, '{10'h0E4, 8'h17, 8'h17, 7'h1C},
    '{10'h0E4, 8'h00, 8'h00, 7'h00}, '{10'h0E4, 8'hF8, 8'h18, 7'h40},
    '{10'h0E4, 8'h1F, 8'h1F, 7'h00}, '{10'h3FC, 8'hFF, 8'h00, 7'h00}};

  pdc_regs pdc_regs_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sync_pin_i(sync_pin),
    .chan_on_first_loop_i(chans), .second_loop_m_divider_o(m_code),
    .second_loop_m_bypass_o(m_bypass), .second_loop_m_ratio_o(m_ratio),
    .first_loop_post_divider_o(p_code), .first_loop_post_ratio_o(post_ratio),
    .first_loop_resync_allow_o(allow), .first_loop_chan_resync_o(resync),
    .first_loop_power_down_o(pdn), .first_loop_enable_o(en),
    .first_loop_calib_reset_o(calib), .primary_ref_doubler_on_o(dbl),
    .first_loop_pump_current_o(cp_code), .first_loop_pump_tenth_ma_o(tenth));

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (calib === 1'b1) calib_n++;
    if (resync !== 8'h00) begin
      sync_n++;
      sync_mask = resync;
    end
  end
  // ----------
  // Tasks
  // ----------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task bus(input logic [9:0] a, input logic [7:0] d, input logic w,
           input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h00_0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task pulse_sync();
    @(posedge clk_i);
    sync_pin <= 1'b1;
    repeat (3) @(posedge clk_i);
    sync_pin <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task final_report();
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      bus(rows[i].a, rows[i].wd, 1'b1, 4'h1);
      bus(rows[i].a, 8'h00, 1'b0, 4'h1);
      chk(rd, {24'h00_0000, rows[i].rd});
      if (rows[i].a == 10'h0DC) begin
        chk(32'(m_ratio), 32'(rows[i].dec));
        chk(32'(m_code), 32'(rows[i].rd[4:0]));
        chk(32'(m_bypass), 32'(rows[i].dec == 7'h01));
      end
      if (rows[i].a == 10'h0E0) begin
        chk(32'(post_ratio), 32'(rows[i].dec));
        chk(32'(p_code), 32'(rows[i].rd[4:2]));
        chk(32'(allow), 32'(rows[i].wd[1]));
      end
      if (rows[i].a == 10'h0E4) begin
        chk(32'(tenth), 32'(rows[i].dec));
        chk(32'(cp_code), 32'(rows[i].rd[3:0]));
        chk(32'(dbl), 32'(rows[i].wd[4]));
      end
    end
    bus(10'h0DC, 8'h05, 1'b1, 4'hE);
    bus(10'h0DC, 8'h00, 1'b0, 4'h1);
    chk(rd, 32'h0000_001F);
    chans <= 8'hA5;
    pulse_sync();
    chk(32'(sync_n), 32'h0000_0001);
    chk(32'(sync_mask), 32'h0000_00A5);
    bus(10'h0E0, 8'h1C, 1'b1, 4'h1);
    pulse_sync();
    chk(32'(sync_n), 32'h0000_0001);
    bus(10'h0E0, 8'h1D, 1'b1, 4'h1);
    @(negedge clk_i);
    chk(32'(pdn), 32'h0000_0001);
    chk(32'(en), 32'h0000_0000);
    bus(10'h0E0, 8'h1D, 1'b1, 4'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(calib_n), 32'h0000_0001);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({25'h0, m_bypass, m_ratio}, 32'h0000_0041);
    chk(32'(post_ratio), 32'h0000_0008);
    chk({29'h0, allow, pdn, en}, 32'h0000_0005);
    chk(32'(dbl), 32'h0000_0001);
    chk(32'(tenth), 32'h0000_0040);
    chk(32'({m_code, p_code, cp_code}), 32'h0000_0078);
    bus(10'h0E4, 8'h00, 1'b0, 4'h1);
    chk(rd, 32'h0000_0018);
    chk(32'(calib_n), 32'h0000_0001);
    final_report();
  end

  initial begin
    #20000;
    errors++;
    final_report();
  end
endmodule
